/* File: logic/rtc_with_backed_ram.sv */
// real-time clock with general RAM, two lockable ranges and a date alarm
// rst_n is the well reset; the secondary reset is a synchronous input
// both resets are inputs only and are never driven from here
`timescale 1ns/1ps
module rtc_with_backed_ram #(
    parameter int XTAL_EDGES = rtc_pkg::XTAL_HZ,
    parameter logic [7:0] LOCK0_BASE = rtc_pkg::LOCK0_BASE_DEF,
    parameter logic [7:0] LOCK1_BASE = rtc_pkg::LOCK1_BASE_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic secondaryWellResetN,
    input wire logic crystalIn,
    output logic crystalOut,
    input wire logic timeLoad,
    input wire rtc_pkg::cal_time_t timeIn,
    output rtc_pkg::cal_time_t timeNow,
    input wire logic alarmLoad,
    input wire rtc_pkg::alarm_t alarmIn,
    output logic alarmArmed,
    output logic wakeEvent,
    input wire logic [1:0] lockSet,
    output logic [1:0] lockActive,
    input wire rtc_pkg::ram_req_t ramReq,
    output logic ramAck,
    output logic ramRefused,
    output logic [7:0] ramRdata
);

    typedef struct packed {
        logic xtalPrev;
        logic xtalOut;
        logic [rtc_pkg::DIV_W-1:0] divCnt;
        logic secTick;
        logic tickSeen;
        logic [1:0] lock;
        rtc_pkg::alarm_t alarm;
        logic armed;
        logic wake;
        logic ack;
        logic refused;
        logic [7:0] rdata;
    } state_t;

    localparam logic [rtc_pkg::DIV_W-1:0] DIV_LAST =
        rtc_pkg::DIV_W'(XTAL_EDGES - 1);

    state_t s_q;
    state_t s_d;
    logic [7:0] ram [rtc_pkg::RAM_BYTES];
    logic [4:0] dayMax;
    logic secCarry;
    logic minCarry;
    logic hourCarry;
    logic dayCarry;
    logic monthCarry;
    logic inLock0;
    logic inLock1;
    logic blocked;
    logic ramWriteOk;
    logic alarmMatch;

    // day limit tracks the running month and year
    assign dayMax = rtc_pkg::days_in_month(timeNow.month, timeNow.year);

    rtc_wrap_counter #(.W(6), .RESET_VALUE(rtc_pkg::SEC_RST)) secCounter (
        .clk(clk),
        .rst_n(rst_n),
        .inc(s_q.secTick),
        .load(timeLoad),
        .loadValue(timeIn.second),
        .minValue(rtc_pkg::SEC_RST),
        .maxValue(rtc_pkg::SEC_MAX),
        .value(timeNow.second),
        .carry(secCarry)
    );

    rtc_wrap_counter #(.W(6), .RESET_VALUE(rtc_pkg::MIN_RST)) minCounter (
        .clk(clk),
        .rst_n(rst_n),
        .inc(secCarry),
        .load(timeLoad),
        .loadValue(timeIn.minute),
        .minValue(rtc_pkg::MIN_RST),
        .maxValue(rtc_pkg::MIN_MAX),
        .value(timeNow.minute),
        .carry(minCarry)
    );

    rtc_wrap_counter #(.W(5), .RESET_VALUE(rtc_pkg::HOUR_RST)) hourCounter (
        .clk(clk),
        .rst_n(rst_n),
        .inc(minCarry),
        .load(timeLoad),
        .loadValue(timeIn.hour),
        .minValue(rtc_pkg::HOUR_RST),
        .maxValue(rtc_pkg::HOUR_MAX),
        .value(timeNow.hour),
        .carry(hourCarry)
    );

    rtc_wrap_counter #(.W(5), .RESET_VALUE(rtc_pkg::DAY_RST)) dayCounter (
        .clk(clk),
        .rst_n(rst_n),
        .inc(hourCarry),
        .load(timeLoad),
        .loadValue(timeIn.day),
        .minValue(rtc_pkg::DAY_MIN),
        .maxValue(dayMax),
        .value(timeNow.day),
        .carry(dayCarry)
    );

    rtc_wrap_counter #(.W(4), .RESET_VALUE(rtc_pkg::MONTH_RST)) monCounter (
        .clk(clk),
        .rst_n(rst_n),
        .inc(dayCarry),
        .load(timeLoad),
        .loadValue(timeIn.month),
        .minValue(rtc_pkg::MONTH_MIN),
        .maxValue(rtc_pkg::MONTH_MAX),
        .value(timeNow.month),
        .carry(monthCarry)
    );

    rtc_wrap_counter #(.W(7), .RESET_VALUE(rtc_pkg::YEAR_RST)) yearCounter (
        .clk(clk),
        .rst_n(rst_n),
        .inc(monthCarry),
        .load(timeLoad),
        .loadValue(timeIn.year),
        .minValue(rtc_pkg::YEAR_RST),
        .maxValue(rtc_pkg::YEAR_MAX),
        .value(timeNow.year),
        .carry()
    );

    // ranges are aligned to eight bytes, so the low three bits are ignored
    assign inLock0 = s_q.lock[0] && (ramReq.addr[7:3] == LOCK0_BASE[7:3]);
    assign inLock1 = s_q.lock[1] && (ramReq.addr[7:3] == LOCK1_BASE[7:3]);
    assign blocked = inLock0 || inLock1;
    assign ramWriteOk = ramReq.req && ramReq.write && !blocked;

    // no month field: day, hour, minute and second match, so a wake can be set up to a month ahead
    assign alarmMatch = (timeNow.day == s_q.alarm.day)
        && (timeNow.hour == s_q.alarm.hour)
        && (timeNow.minute == s_q.alarm.minute)
        && (timeNow.second == s_q.alarm.second);

    always_comb begin
        s_d = s_q;
        s_d.xtalPrev = crystalIn;
        // inverting feedback keeps an attached crystal oscillating
        s_d.xtalOut = ~crystalIn;
        s_d.secTick = 1'b0;
        if (crystalIn && !s_q.xtalPrev) begin
            if (s_q.divCnt >= DIV_LAST) begin
                s_d.divCnt = '0;
                s_d.secTick = 1'b1;
            end else begin
                s_d.divCnt = rtc_pkg::DIV_W'(s_q.divCnt + 1'b1);
            end
        end
        // compare one cycle after the tick, once the counters settled
        s_d.tickSeen = s_q.secTick;
        if (timeLoad) begin
            s_d.divCnt = '0;
        end

        s_d.wake = 1'b0;
        if (s_q.armed && s_q.tickSeen && alarmMatch) begin
            s_d.wake = 1'b1;
            s_d.armed = 1'b0;
        end
        if (alarmLoad) begin
            s_d.alarm = alarmIn;
            s_d.armed = 1'b1;
        end

        // locks are sticky; only a reset removes them
        s_d.lock = s_q.lock | lockSet;
        if (!secondaryWellResetN) begin
            s_d.lock = '0;
        end

        s_d.ack = ramReq.req;
        s_d.refused = ramReq.req && blocked;
        if (ramReq.req && !ramReq.write) begin
            s_d.rdata = blocked ? rtc_pkg::LOCKED_READ
                : ram[ramReq.addr];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // contents survive resets: only the well supply loss clears them
    always_ff @(posedge clk) begin
        if (ramWriteOk) begin
            ram[ramReq.addr] <= ramReq.wdata;
        end
    end

    // no output reaches either reset pin; both are pure inputs
    assign crystalOut = s_q.xtalOut;
    assign alarmArmed = s_q.armed;
    assign wakeEvent = s_q.wake;
    assign lockActive = s_q.lock;
    assign ramAck = s_q.ack;
    assign ramRefused = s_q.refused;
    assign ramRdata = s_q.rdata;

endmodule : rtc_with_backed_ram

/* File: logic/rtc_pkg.sv */
// constants, types and helpers shared by the real-time clock block
// assumes a 25 MHz system clock and a 32.768 kHz crystal input
package rtc_pkg;

    localparam int XTAL_HZ = 32768;
    localparam int DIV_W = 16;
    localparam int RAM_BYTES = 256;
    localparam int RAM_AW = 8;
    localparam int LOCK_REGIONS = 2;
    localparam int LOCK_BYTES = 8;
    localparam logic [7:0] LOCK0_BASE_DEF = 8'h38;
    localparam logic [7:0] LOCK1_BASE_DEF = 8'hF8;
    localparam logic [7:0] LOCKED_READ = 8'hFF;

    localparam logic [5:0] SEC_RST = 6'h00;
    localparam logic [5:0] MIN_RST = 6'h00;
    localparam logic [4:0] HOUR_RST = 5'h00;
    localparam logic [4:0] DAY_RST = 5'h01;
    localparam logic [3:0] MONTH_RST = 4'h1;
    localparam logic [6:0] YEAR_RST = 7'h00;

    localparam logic [5:0] SEC_MAX = 6'h3B;
    localparam logic [5:0] MIN_MAX = 6'h3B;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [3:0] MONTH_MAX = 4'hC;
    localparam logic [6:0] YEAR_MAX = 7'h63;
    localparam logic [4:0] DAY_MIN = 5'h01;
    localparam logic [3:0] MONTH_MIN = 4'h1;

    typedef struct packed {
        logic [6:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
    } cal_time_t;

    typedef struct packed {
        logic [4:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
    } alarm_t;

    typedef struct packed {
        logic req;
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ram_req_t;

    // two-digit year: every year divisible by four is a leap year
    function automatic logic [4:0] days_in_month(
        input logic [3:0] month,
        input logic [6:0] year
    );
        logic [4:0] days;
        days = 5'h1F;
        case (month)
            4'h4, 4'h6, 4'h9, 4'hB: days = 5'h1E;
            4'h2: days = (year[1:0] == 2'h0) ? 5'h1D : 5'h1C;
            default: days = 5'h1F;
        endcase
        return days;
    endfunction : days_in_month

endpackage : rtc_pkg

/* File: logic/rtc_wrap_counter.sv */
// one calendar field: counts from a minimum to a maximum and wraps
// assumes inc and load never needed in the same cycle; load wins
`timescale 1ns/1ps
module rtc_wrap_counter #(
    parameter int W = 6,
    parameter logic [W-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inc,
    input wire logic load,
    input wire logic [W-1:0] loadValue,
    input wire logic [W-1:0] minValue,
    input wire logic [W-1:0] maxValue,
    output logic [W-1:0] value,
    output logic carry
);

    logic [W-1:0] value_q;
    logic [W-1:0] value_d;

    // >= so a day past a shortened month still wraps
    assign carry = inc && !load && (value_q >= maxValue);
    assign value = value_q;

    always_comb begin
        value_d = value_q;
        if (load) begin
            value_d = loadValue;
        end else if (carry) begin
            value_d = minValue;
        end else if (inc) begin
            value_d = W'(value_q + 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= RESET_VALUE;
        end else begin
            value_q <= value_d;
        end
    end

endmodule : rtc_wrap_counter

/* File: verification/rtc_with_backed_ram_sva.sv */
// port-level checks for the rtc block
// assumes one clk domain, rst_n async active low
`timescale 1ns/1ps
module rtc_chk #(
    parameter logic [7:0] LOCK0_BASE = 8'h38,
    parameter logic [7:0] LOCK1_BASE = 8'hF8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic secondaryWellResetN,
    input wire logic crystalIn,
    input wire logic crystalOut,
    input wire logic timeLoad,
    input wire rtc_pkg::cal_time_t timeIn,
    input wire rtc_pkg::cal_time_t timeNow,
    input wire logic alarmLoad,
    input wire logic alarmArmed,
    input wire logic wakeEvent,
    input wire logic [1:0] lockSet,
    input wire logic [1:0] lockActive,
    input wire rtc_pkg::ram_req_t ramReq,
    input wire logic ramAck,
    input wire logic ramRefused,
    input wire logic [7:0] ramRdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic hit;
    assign hit = ramReq.req
        && ((ramReq.addr[7:3] == LOCK0_BASE[7:3] && lockActive[0])
        || (ramReq.addr[7:3] == LOCK1_BASE[7:3] && lockActive[1]));
    sequence s_lockedRead;
        hit && !ramReq.write;
    endsequence
    property p_lockedRead;
        s_lockedRead |=> ramRefused && ramRdata == rtc_pkg::LOCKED_READ;
    endproperty
    a_lockedRead: assert property (p_lockedRead)
        else $error("locked read exposed data");
    property p_ack;
        ramReq.req |=> ramAck && ramRefused == $past(hit);
    endproperty
    a_ack: assert property (p_ack)
        else $error("ram answer wrong");
    property p_lockSet;
        secondaryWellResetN
            |=> lockActive == ($past(lockActive) | $past(lockSet));
    endproperty
    a_lockSet: assert property (p_lockSet)
        else $error("lock bits wrong");
    property p_secReset;
        !secondaryWellResetN |=> lockActive == 2'h0;
    endproperty
    a_secReset: assert property (p_secReset)
        else $error("secondary reset kept a lock");
    property p_timeLoad;
        timeLoad |=> timeNow == $past(timeIn);
    endproperty
    a_timeLoad: assert property (p_timeLoad)
        else $error("time load lost");
    property p_wake;
        wakeEvent |-> $past(alarmArmed) ##1 !wakeEvent;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake without arming or too long");
    property p_armed;
        alarmLoad |=> alarmArmed;
    endproperty
    a_armed: assert property (p_armed)
        else $error("alarm not armed");
    property p_xtal;
        $past(rst_n) |-> crystalOut == !$past(crystalIn);
    endproperty
    a_xtal: assert property (p_xtal)
        else $error("crystal output wrong");
endmodule : rtc_chk

bind rtc_with_backed_ram rtc_chk #(.LOCK0_BASE(LOCK0_BASE),
    .LOCK1_BASE(LOCK1_BASE)) chk (.clk, .rst_n, .secondaryWellResetN,
    .crystalIn, .crystalOut, .timeLoad, .timeIn, .timeNow, .alarmLoad,
    .alarmArmed, .wakeEvent, .lockSet, .lockActive, .ramReq, .ramAck,
    .ramRefused, .ramRdata);

/* File: verification/rtc_platform_model.sv */
// platform side: free-running crystal and secondary reset
// assumes a 25 MHz clk; HALF clk cycles per crystal half period
`timescale 1ns/1ps
module rtc_platform_model #(
    parameter int HALF = 381
) (
    input wire logic clk,
    input wire logic pull,
    output logic crystalIn,
    output logic secondaryWellResetN
);
    int cnt = 0;
    logic xtal = 1'b0;
    // high from power-up, so it is up before any power-good
    logic srst = 1'b1;
    assign crystalIn = xtal;
    assign secondaryWellResetN = srst;
    // oscillator never stops, so no idle level
    always @(posedge clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) xtal <= !xtal;
        srst <= !pull;
    end
endmodule : rtc_platform_model

/* File: verification/rtc_with_backed_ram_tb_top.sv */
// self-checking bench for the rtc block
// assumes the platform model supplies crystal and secondary reset
`timescale 1ns/1ps
module rtc_with_backed_ram_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, pull = 1'b0;
    logic timeLoad = 1'b0, alarmLoad = 1'b0;
    logic [1:0] lockSet = 2'h0, lockActive;
    logic crystalIn, crystalOut, secondaryWellResetN;
    logic alarmArmed, wakeEvent, ramAck, ramRefused;
    logic [7:0] ramRdata, ad, mem [256];
    logic [31:0] lfsr = 32'h00015CE1;
    rtc_pkg::cal_time_t timeIn = '0, timeNow, nx;
    rtc_pkg::cal_time_t st [3] = '{{7'h03, 4'hC, 5'h1F, 5'h17, 6'h3B,
        6'h3B}, {7'h04, 4'h2, 5'h1C, 5'h17, 6'h3B, 6'h3B},
        {7'h05, 4'h2, 5'h1C, 5'h17, 6'h3B, 6'h3B}};
    rtc_pkg::alarm_t alarmIn = '0;
    rtc_pkg::ram_req_t ramReq = '0;
    int error_cnt = 0, checks = 0;
    always #20 clk = ~clk;
    rtc_platform_model plat (.clk, .pull, .crystalIn,
        .secondaryWellResetN);
    rtc_with_backed_ram #(.XTAL_EDGES(4)) dut (.clk, .rst_n,
        .secondaryWellResetN, .crystalIn, .crystalOut, .timeLoad,
        .timeIn, .timeNow, .alarmLoad, .alarmIn, .alarmArmed,
        .wakeEvent, .lockSet, .lockActive, .ramReq, .ramAck,
        .ramRefused, .ramRdata);
    function automatic rtc_pkg::cal_time_t nxt(rtc_pkg::cal_time_t t);
        logic [4:0] dim;
        logic s, m, h, d;
        dim = t.month inside {4'h4, 4'h6, 4'h9, 4'hB} ? 5'h1E : 5'h1F;
        if (t.month == 4'h2) dim = t.year[1:0] == 2'h0 ? 5'h1D : 5'h1C;
        s = t.second == 6'h3B;
        m = s && t.minute == 6'h3B;
        h = m && t.hour == 5'h17;
        d = h && t.day == dim;
        t.second = s ? 6'h00 : t.second + 6'h01;
        if (s) t.minute = m ? 6'h00 : t.minute + 6'h01;
        if (m) t.hour = h ? 5'h00 : t.hour + 5'h01;
        if (h) t.day = d ? 5'h01 : t.day + 5'h01;
        if (d) t.month = t.month == 4'hC ? 4'h1 : t.month + 4'h1;
        if (d && t.month == 4'h1) t.year = t.year + 7'h01;
        return t;
    endfunction : nxt
    function automatic logic [31:0] lfsr_next(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    task automatic chk(logic [32:0] got, logic [32:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic ram(logic w, logic [7:0] a, logic [7:0] d,
        logic r, logic [7:0] e);
        @(posedge clk);
        ramReq <= '{1'b1, w, a, d};
        @(posedge clk);
        ramReq.req <= 1'b0;
        #1;
        chk({ramAck, ramRefused}, {1'b1, r});
        if (!w) chk(ramRdata, e);
    endtask : ram
    task automatic stop_test;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    initial begin
        #2400000;
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(timeNow, {7'h00, 4'h1, 5'h01, 17'h0});
        for (int i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            mem[lfsr[7:0]] = lfsr[15:8];
            ram(1'b1, lfsr[7:0], lfsr[15:8], 1'b0, 8'h00);
        end
        foreach (mem[i]) begin
            if (mem[i] !== 8'hxx) begin
                ram(1'b0, 8'(i), 8'h00, 1'b0, mem[i]);
            end
        end
        // edges around range zero, the first byte of range one, and two bytes inside range zero, 3A and its last byte 3F
        for (int k = 0; k < 5; k++) begin
            ad = 8'(40'h373A3F40F8 >> (8 * (4 - k)));
            ram(1'b1, ad, ad ^ 8'h5A, 1'b0, 8'h00);
        end
        @(posedge clk);
        lockSet <= 2'h3;
        @(posedge clk);
        lockSet <= 2'h0;
        ram(1'b0, 8'h3A, 8'h00, 1'b1, 8'hFF);
        ram(1'b1, 8'h3F, 8'h11, 1'b1, 8'h00);
        ram(1'b0, 8'hF8, 8'h00, 1'b1, 8'hFF);
        ram(1'b0, 8'h40, 8'h00, 1'b0, 8'h1A);
        ram(1'b0, 8'h37, 8'h00, 1'b0, 8'h6D);
        pull <= 1'b1;
        repeat (4) @(posedge clk);
        pull <= 1'b0;
        #1;
        chk(lockActive, 2'h0);
        ram(1'b0, 8'h3A, 8'h00, 1'b0, 8'h60);
        // the refused write must have left the old byte in place
        ram(1'b0, 8'h3F, 8'h00, 1'b0, 8'h65);
        foreach (st[i]) begin
            nx = nxt(st[i]);
            @(posedge clk);
            timeLoad <= 1'b1;
            timeIn <= st[i];
            alarmLoad <= i == 1;
            alarmIn <= nx[21:0];
            @(posedge clk);
            timeLoad <= 1'b0;
            alarmLoad <= 1'b0;
            // step off the load edge so the loaded time is settled
            #1;
            for (int n = 0; n < 4000 && timeNow === st[i]; n++) begin
                @(posedge clk) #1;
            end
            chk(timeNow, nx);
            // wake stands for the one cycle after the new second
            @(posedge clk);
            #1;
            chk({wakeEvent, alarmArmed}, {i == 1, 1'b0});
        end
        @(posedge clk);
        lockSet <= 2'h1;
        @(posedge clk);
        lockSet <= 2'h0;
        @(posedge clk);
        rst_n <= 1'b0;
        #1;
        chk(timeNow, {7'h00, 4'h1, 5'h01, 17'h0});
        chk(lockActive, 2'h0);
        @(posedge clk);
        rst_n <= 1'b1;
        ram(1'b0, 8'h40, 8'h00, 1'b0, 8'h1A);
        stop_test();
    end
endmodule : rtc_with_backed_ram_tb_top
